// ---- rtl/ssf_pkg.sv ----
// Shared constants and types for the system status flag bank
package ssf_pkg;
   // ==========================================================
   // Clock and timing
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
   localparam int unsigned AC_DROP_MS = 20;
   localparam int unsigned DC_DROP_MS = 10;
   localparam int unsigned AC_DROP_CYC = AC_DROP_MS * CYC_PER_MS;
   localparam int unsigned DC_DROP_CYC = DC_DROP_MS * CYC_PER_MS;
   localparam int unsigned OP_CYCLE_US = 1000;
   localparam int unsigned OP_CYCLE_CYC = OP_CYCLE_US * (CLK_HZ / 1_000_000);
   localparam int unsigned SEC_MS = 1000;
   localparam int unsigned SEC_CYC = SEC_MS * CYC_PER_MS;
   localparam int unsigned DROP_CNT_W = 20;
   localparam int unsigned DIV_CNT_W = 25;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_CLK0 = 8'h08;
   localparam logic [7:0] OFS_CLK1 = 8'h0C;
   localparam logic [7:0] OFS_CLK2 = 8'h10;
   localparam logic [7:0] OFS_CLK3 = 8'h14;
   localparam logic [7:0] OFS_WDT_CAUSE = 8'h18;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

   // ==========================================================
   // Control register fields
   localparam int unsigned CTL_CLK_SET = 0;
   localparam int unsigned CTL_CLK_READ = 1;
   localparam int unsigned CTL_ERR_CLR = 2;
   localparam int unsigned CTL_HOST_RDY = 3;
   localparam int unsigned CTL_EXT_BAT = 4;
   localparam int unsigned CTL_W = 5;
   localparam logic [CTL_W-1:0] CTL_RESET = 5'h00;
   localparam int unsigned STAT_W = 14;
   localparam logic [15:0] WORD_ZERO = 16'h0000;

   // ==========================================================
   // Status flags, bit 0 first (fuse) up to bit 13 (test request error)
   typedef struct packed {
      logic test_request_error_flag;
      logic forced_stop_input_flag;
      logic test_mode_active_flag;
      logic motion_ready_complete_flag;
      logic motion_watchdog_error_flag;
      logic constant_zero_flag;
      logic constant_one_flag;
      logic clock_data_error_flag;
      logic general_diag_error_flag;
      logic self_check_error_flag;
      logic battery_low_latched_flag;
      logic battery_low_live_flag;
      logic supply_dropout_flag;
      logic fuse_fault_flag;
   } ssf_status_s;

   // Clock data words: {year,month} {day,hour} {minute,second} {0,weekday}
   typedef struct packed {
      logic [15:0] w3;
      logic [15:0] w2;
      logic [15:0] w1;
      logic [15:0] w0;
   } ssf_clock_s;

   // Two BCD digits in range lo..hi
   function automatic logic bcd_ok(input logic [7:0] v, input logic [7:0] lo,
                                   input logic [7:0] hi);
      bcd_ok = (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v >= lo) && (v <= hi);
   endfunction

   // BCD increment with wrap to zero after max
   function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] max);
      if (v == max) begin
         bcd_inc = 8'h00;
      end else if (v[3:0] == 4'h9) begin
         bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
         bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
   endfunction
endpackage

// ---- rtl/ssf_rise_det.sv ----
// Rising edge detector for request levels
`timescale 1ns/100ps
`default_nettype none
module ssf_rise_det #(
   parameter int unsigned W = 1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Level in, pulse out
   input wire logic [W-1:0] level_i,
   output logic [W-1:0] rise_o
);
   logic [W-1:0] prev_q;

   // Previous level, low after reset so a level already high counts once
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         prev_q <= '0;
      end else begin
         prev_q <= level_i;
      end
   end

   assign rise_o = level_i & ~prev_q;
endmodule // ssf_rise_det
`default_nettype wire

// ---- rtl/ssf_rtc.sv ----
// Time-of-day element: BCD seconds, minutes and hours run from a tick
`timescale 1ns/100ps
`default_nettype none
module ssf_rtc #(
   parameter int unsigned SEC_CYC = ssf_pkg::SEC_CYC
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Load from clock data words
   input wire logic load_i,
   input wire ssf_pkg::ssf_clock_s load_val_i,
   // Current time
   output ssf_pkg::ssf_clock_s time_o
);
   logic [ssf_pkg::DIV_CNT_W-1:0] div_q;
   logic sec_tick;
   logic sec_wrap;
   logic min_wrap;
   ssf_pkg::ssf_clock_s time_q;
   ssf_pkg::ssf_clock_s time_d;

   // One-second enable; date fields are held, only the time of day runs
   assign sec_tick = (div_q == ssf_pkg::DIV_CNT_W'(SEC_CYC - 1));
   assign sec_wrap = (time_q.w2[7:0] == 8'h59);
   assign min_wrap = sec_wrap && (time_q.w2[15:8] == 8'h59);

   always_comb begin
      time_d = time_q;
      time_d.w2[7:0] = ssf_pkg::bcd_inc(time_q.w2[7:0], 8'h59);
      if (sec_wrap) begin
         time_d.w2[15:8] = ssf_pkg::bcd_inc(time_q.w2[15:8], 8'h59);
      end
      if (min_wrap) begin
         time_d.w1[7:0] = ssf_pkg::bcd_inc(time_q.w1[7:0], 8'h23);
      end
   end

   // Divider and time register; a load restarts the second
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         div_q <= '0;
         time_q <= '0;
      end else if (load_i) begin
         div_q <= '0;
         time_q <= load_val_i;
      end else begin
         div_q <= sec_tick ? '0 : div_q + 1'b1;
         if (sec_tick) begin
            time_q <= time_d;
         end
      end
   end

   assign time_o = time_q;
endmodule // ssf_rtc
`default_nettype wire

// ---- rtl/ssf_flag_bank.sv ----
// System status and request flag bank with APB register access
// Functional notes
// - Fuse fault flag sets on any blown-fuse report and stays set.
// - Dropout flag sets on short supply loss; only power-on reset clears it.
// - Live battery-low follows the voltage and indicator, only if enabled.
// - Latched battery-low flag sets on low voltage, only if enabled, and stays set.
// - Self-check error flag sets on self-diagnosis fault and stays set.
// - General diagnostic error flag sets on any diagnosis error, stays set.
// - Clock-set request rising edge loads valid clock data words into clock.
// - Clock data error flag reflects invalid clock words, updated on request.
// - While clock-read is high, clock words take the current BCD time.
// - Constant-one flag always reads high.
// - Constant-zero flag always reads low.
// - Rising error-clear request clears the current error flags.
// - Watchdog timeout sets flag, stops axes at once, records cause.
// - Host-ready rise runs parameter check; ready flag sets if no error.
// - Ready complete flag clears as soon as host-ready goes low.
// - Test-mode-active flag is high while granted test mode lasts.
// - Refused test-mode request sets the test request error flag instead.
// - Forced-stop flag updates each operation cycle; high means released.
`timescale 1ns/100ps
`default_nettype none
module ssf_flag_bank #(
   parameter int unsigned ADDR_W = 8,
   parameter int unsigned AC_DROP_CYC = ssf_pkg::AC_DROP_CYC,
   parameter int unsigned DC_DROP_CYC = ssf_pkg::DC_DROP_CYC,
   parameter int unsigned OP_CYCLE_CYC = ssf_pkg::OP_CYCLE_CYC,
   parameter int unsigned SEC_CYC = ssf_pkg::SEC_CYC
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // System condition inputs
   input wire logic fuse_blown_i,
   input wire logic supply_low_i,
   input wire logic supply_is_dc_i,
   input wire logic battery_low_i,
   input wire logic self_diag_fault_i,
   input wire logic diag_fault_i,
   input wire logic wdt_timeout_i,
   input wire logic [15:0] wdt_cause_i,
   input wire logic param_check_ok_i,
   input wire logic test_req_i,
   input wire logic test_grant_i,
   input wire logic test_end_i,
   input wire logic estop_applied_i,
   // Outputs to the system
   output logic battery_led_o,
   output logic axes_stop_o,
   output logic irq_o
);
   // ==========================================================
   // Declarations
   logic [ssf_pkg::CTL_W-1:0] ctrl_q;
   logic [ssf_pkg::CTL_W-1:0] ctrl_rise;
   ssf_pkg::ssf_status_s stat_q;
   ssf_pkg::ssf_status_s stat_d;
   ssf_pkg::ssf_status_s stat_set;
   logic [ssf_pkg::STAT_W-1:0] irq_stat_q;
   logic [ssf_pkg::STAT_W-1:0] irq_mask_q;
   ssf_pkg::ssf_clock_s clk_words_q;
   ssf_pkg::ssf_clock_s rtc_time;
   logic [15:0] wdt_cause_q;
   logic [31:0] rdata_q;
   logic [ssf_pkg::DROP_CNT_W-1:0] drop_cnt_q;
   logic supply_low_q;
   logic [ssf_pkg::DIV_CNT_W-1:0] op_div_q;
   logic op_tick;
   logic check_pend_q;
   logic drop_short;
   logic clk_words_ok;
   logic err_clr;
   logic clk_set_go;
   logic bat_chk;

   // ==========================================================
   // APB decode
   wire logic setup_ph = psel && !penable;
   wire logic access_ph = psel && penable;
   wire logic [7:0] ofs = paddr[7:0];
   wire logic hit_status = (ofs == ssf_pkg::OFS_STATUS);
   wire logic hit_ctrl = (ofs == ssf_pkg::OFS_CTRL);
   wire logic hit_clk0 = (ofs == ssf_pkg::OFS_CLK0);
   wire logic hit_clk1 = (ofs == ssf_pkg::OFS_CLK1);
   wire logic hit_clk2 = (ofs == ssf_pkg::OFS_CLK2);
   wire logic hit_clk3 = (ofs == ssf_pkg::OFS_CLK3);
   wire logic hit_cause = (ofs == ssf_pkg::OFS_WDT_CAUSE);
   wire logic hit_istat = (ofs == ssf_pkg::OFS_IRQ_STAT);
   wire logic hit_imask = (ofs == ssf_pkg::OFS_IRQ_MASK);
   wire logic hit_any = hit_status | hit_ctrl | hit_clk0 | hit_clk1 | hit_clk2
                      | hit_clk3 | hit_cause | hit_istat | hit_imask;
   wire logic wr_en = access_ph && pwrite && hit_any;

   // Zero wait state; unmapped offsets answer with an error and change nothing
   assign pready = 1'b1;
   assign pslverr = access_ph && !hit_any;
   assign prdata = rdata_q;

   // Read mux, sampled in the setup cycle so prdata comes from a flop
   wire logic [31:0] rd_mux =
        hit_status ? {18'h0_0000, stat_q}
      : hit_ctrl ? {27'h000_0000, ctrl_q}
      : hit_clk0 ? {16'h0000, clk_words_q.w0}
      : hit_clk1 ? {16'h0000, clk_words_q.w1}
      : hit_clk2 ? {16'h0000, clk_words_q.w2}
      : hit_clk3 ? {16'h0000, clk_words_q.w3}
      : hit_cause ? {16'h0000, wdt_cause_q}
      : hit_istat ? {18'h0_0000, irq_stat_q}
      : hit_imask ? {18'h0_0000, irq_mask_q}
      : 32'h0000_0000;

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rdata_q <= 32'h0000_0000;
      end else if (setup_ph) begin
         rdata_q <= rd_mux;
      end
   end

   // ==========================================================
   // Control register: software request levels
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         ctrl_q <= ssf_pkg::CTL_RESET;
      end else if (wr_en && hit_ctrl) begin
         ctrl_q <= pwdata[ssf_pkg::CTL_W-1:0];
      end
   end

   // One edge detector for all request bits
   ssf_rise_det #(
      .W(ssf_pkg::CTL_W)
   ) u_req_rise (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .level_i(ctrl_q),
      .rise_o(ctrl_rise)
   );

   assign err_clr = ctrl_rise[ssf_pkg::CTL_ERR_CLR];
   assign bat_chk = ctrl_q[ssf_pkg::CTL_EXT_BAT];
   wire logic host_rdy = ctrl_q[ssf_pkg::CTL_HOST_RDY];
   wire logic clk_read = ctrl_q[ssf_pkg::CTL_CLK_READ];

   // ==========================================================
   // Clock data words and time-of-day element
   assign clk_words_ok =
        ssf_pkg::bcd_ok(clk_words_q.w0[15:8], 8'h00, 8'h99)
      & ssf_pkg::bcd_ok(clk_words_q.w0[7:0], 8'h01, 8'h12)
      & ssf_pkg::bcd_ok(clk_words_q.w1[15:8], 8'h01, 8'h31)
      & ssf_pkg::bcd_ok(clk_words_q.w1[7:0], 8'h00, 8'h23)
      & ssf_pkg::bcd_ok(clk_words_q.w2[15:8], 8'h00, 8'h59)
      & ssf_pkg::bcd_ok(clk_words_q.w2[7:0], 8'h00, 8'h59)
      & ssf_pkg::bcd_ok(clk_words_q.w3[7:0], 8'h00, 8'h06)
      & (clk_words_q.w3[15:8] == 8'h00);
   // Bad words never reach the clock element
   assign clk_set_go = ctrl_rise[ssf_pkg::CTL_CLK_SET] && clk_words_ok;

   ssf_rtc #(
      .SEC_CYC(SEC_CYC)
   ) u_rtc (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .load_i(clk_set_go),
      .load_val_i(clk_words_q),
      .time_o(rtc_time)
   );

   // Hardware copy wins over software writes while a read is requested
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         clk_words_q <= '0;
      end else if (clk_read) begin
         clk_words_q <= rtc_time;
      end else if (wr_en) begin
         if (hit_clk0) clk_words_q.w0 <= pwdata[15:0];
         if (hit_clk1) clk_words_q.w1 <= pwdata[15:0];
         if (hit_clk2) clk_words_q.w2 <= pwdata[15:0];
         if (hit_clk3) clk_words_q.w3 <= pwdata[15:0];
      end
   end

   // ==========================================================
   // Supply dropout: measure each loss of supply in cycles
   wire logic [ssf_pkg::DROP_CNT_W-1:0] drop_lim = supply_is_dc_i
      ? ssf_pkg::DROP_CNT_W'(DC_DROP_CYC) : ssf_pkg::DROP_CNT_W'(AC_DROP_CYC);
   // A loss that reaches the limit is a real power-off, not a dropout
   assign drop_short = supply_low_q && !supply_low_i && (drop_cnt_q < drop_lim);

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         supply_low_q <= 1'b0;
         drop_cnt_q <= '0;
      end else begin
         supply_low_q <= supply_low_i;
         if (!supply_low_i) begin
            drop_cnt_q <= '0;
         end else if (drop_cnt_q < drop_lim) begin
            drop_cnt_q <= drop_cnt_q + 1'b1;
         end
      end
   end

   // ==========================================================
   // Operation cycle enable for the forced-stop sample
   assign op_tick = (op_div_q == ssf_pkg::DIV_CNT_W'(OP_CYCLE_CYC - 1));

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         op_div_q <= '0;
      end else begin
         op_div_q <= op_tick ? '0 : op_div_q + 1'b1;
      end
   end

   // ==========================================================
   // Set terms of each event flag (none for the constants or forced-stop), used for the next state and for interrupts
   always_comb begin
      stat_set = '0;
      stat_set.fuse_fault_flag = fuse_blown_i;
      stat_set.supply_dropout_flag = drop_short;
      stat_set.battery_low_live_flag = bat_chk && battery_low_i;
      stat_set.battery_low_latched_flag = bat_chk && battery_low_i;
      stat_set.self_check_error_flag = self_diag_fault_i;
      stat_set.general_diag_error_flag = diag_fault_i;
      stat_set.clock_data_error_flag = ctrl_rise[ssf_pkg::CTL_CLK_SET]
                                       && !clk_words_ok;
      stat_set.motion_watchdog_error_flag = wdt_timeout_i;
      stat_set.motion_ready_complete_flag = check_pend_q && host_rdy
                                            && param_check_ok_i;
      stat_set.test_mode_active_flag = test_req_i && test_grant_i;
      stat_set.test_request_error_flag = test_req_i && !test_grant_i;
   end

   // Next status: sticky flags hold, set beats clear
   always_comb begin
      stat_d = stat_q;
      // Latched errors drop on an error clear unless set again this cycle
      if (err_clr) begin
         stat_d.fuse_fault_flag = 1'b0;
         stat_d.battery_low_latched_flag = 1'b0;
         stat_d.self_check_error_flag = 1'b0;
         stat_d.general_diag_error_flag = 1'b0;
         stat_d.clock_data_error_flag = 1'b0;
         stat_d.motion_watchdog_error_flag = 1'b0;
         stat_d.test_request_error_flag = 1'b0;
      end
      // A good clock-set request refreshes the error flag to clean
      if (ctrl_rise[ssf_pkg::CTL_CLK_SET] && clk_words_ok) begin
         stat_d.clock_data_error_flag = 1'b0;
      end
      if (!host_rdy) begin
         stat_d.motion_ready_complete_flag = 1'b0;
      end
      if (test_end_i) begin
         stat_d.test_mode_active_flag = 1'b0;
      end
      stat_d = stat_d | stat_set;
      // Live bits follow their conditions directly
      stat_d.battery_low_live_flag = stat_set.battery_low_live_flag;
      stat_d.constant_one_flag = 1'b1;
      stat_d.constant_zero_flag = 1'b0;
      if (op_tick) begin
         stat_d.forced_stop_input_flag = !estop_applied_i;
      end
   end

   // Status register; everything starts low at power-on
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         stat_q <= '0;
      end else begin
         stat_q <= stat_d;
      end
   end

   // Parameter check runs one cycle after host-ready rises
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         check_pend_q <= 1'b0;
      end else begin
         check_pend_q <= ctrl_rise[ssf_pkg::CTL_HOST_RDY];
      end
   end

   // Watchdog cause captured with the timeout
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         wdt_cause_q <= ssf_pkg::WORD_ZERO;
      end else if (wdt_timeout_i) begin
         wdt_cause_q <= wdt_cause_i;
      end
   end

   // Axes stop at once, straight from the timeout, and stay stopped
   assign axes_stop_o = wdt_timeout_i || stat_q.motion_watchdog_error_flag;
   assign battery_led_o = stat_q.battery_low_live_flag;

   // ==========================================================
   // Interrupt status (write one to clear, set wins) and mask
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         irq_stat_q <= '0;
         irq_mask_q <= '0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~((wr_en && hit_istat)
                       ? pwdata[ssf_pkg::STAT_W-1:0] : '0)) | stat_set;
         if (wr_en && hit_imask) begin
            irq_mask_q <= pwdata[ssf_pkg::STAT_W-1:0];
         end
      end
   end

   assign irq_o = |(irq_stat_q & irq_mask_q);
endmodule // ssf_flag_bank
`default_nettype wire

// ---- bench/ssf_flag_bank_asserts.sv ----
// Port-level checker for the status flag bank
`timescale 1ns/100ps
`default_nettype none
module ssf_flag_bank_asserts #(
   parameter int unsigned ADDR_W = 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // System side
   input wire logic fuse_blown_i,
   input wire logic battery_low_i,
   input wire logic wdt_timeout_i,
   input wire logic battery_led_o,
   input wire logic axes_stop_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);
   // =====
   // Access phase decode
   logic acc;
   logic st_rd;
   assign acc = psel && penable;
   assign st_rd = acc && !pwrite && (paddr == 8'h00);
   // Zero-wait slave, so a stuck ready shows at once
   AST_ZERO_WAIT: assert property (acc |-> pready) else $error("access without ready");
   AST_UNMAPPED: assert property (acc && paddr > 8'h20 |-> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");
   AST_MAPPED: assert property (acc && paddr <= 8'h20 && paddr[1:0] == 2'b00 |-> !pslverr)
      else $error("mapped access refused");
   AST_WDT_STOP: assert property (wdt_timeout_i |-> axes_stop_o)
      else $error("axes not stopped on timeout");
   AST_WDT_HOLD: assert property ($rose(wdt_timeout_i) |=> axes_stop_o)
      else $error("watchdog stop not held");
   AST_LED_OFF: assert property (!battery_low_i |=> !battery_led_o)
      else $error("battery indicator lit with good battery");
   AST_CONST: assert property (st_rd |-> prdata[8:7] == 2'b01 && prdata[31:14] == 18'h0)
      else $error("constant flags wrong");
   // Two edges: flag lands one edge after the input, read data one edge later
   AST_FUSE: assert property (st_rd && $past(fuse_blown_i, 2) && $past(resetn_i, 2)
      |-> prdata[0])
      else $error("fuse flag missing");
endmodule // ssf_flag_bank_asserts
bind ssf_flag_bank ssf_flag_bank_asserts #(.ADDR_W(ADDR_W)) u_chk (
   .clk_i(clk_i), .resetn_i(resetn_i), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .fuse_blown_i(fuse_blown_i), .battery_low_i(battery_low_i), .wdt_timeout_i(wdt_timeout_i),
   .battery_led_o(battery_led_o), .axes_stop_o(axes_stop_o));
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the status flag bank
`timescale 1ns/100ps
`default_nettype none
module tb;
   // =====
   // Stimulus and observed signals
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd_q;
   logic pready, pslverr, err_q, led, stop, irq;
   logic fuse = 1'b0, sup = 1'b0, dc = 1'b0, bat = 1'b0, sdg = 1'b0, dg = 1'b0;
   logic wdt = 1'b0, pok = 1'b0, treq = 1'b0, tgr = 1'b0, tend = 1'b0, est = 1'b0;
   logic [15:0] cause = 16'h0000;
   int err_count = 0;
   int check_count = 0;
   // Short counts keep the run brief
   ssf_flag_bank #(.OP_CYCLE_CYC(16), .SEC_CYC(20), .AC_DROP_CYC(40), .DC_DROP_CYC(20)) dut (
      .clk_i(clk_i), .resetn_i(resetn_i), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fuse_blown_i(fuse), .supply_low_i(sup), .supply_is_dc_i(dc), .battery_low_i(bat),
      .self_diag_fault_i(sdg), .diag_fault_i(dg), .wdt_timeout_i(wdt), .wdt_cause_i(cause),
      .param_check_ok_i(pok), .test_req_i(treq), .test_grant_i(tgr), .test_end_i(tend),
      .estop_applied_i(est), .battery_led_o(led), .axes_stop_o(stop), .irq_o(irq));
   // 25 MHz clock
   always #20 clk_i = ~clk_i;
   // =====
   // Shared tasks
   task automatic complete_run();
      if (err_count == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic ck(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic ckb(input logic got, input logic exp);
      ck({31'h0, got}, {31'h0, exp});
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // One APB transfer; request held until ready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      @(posedge clk_i);
      while (pready !== 1'b1) begin
         n++;
         if (n > 50) begin
            err_count++;
            complete_run();
         end
         @(posedge clk_i);
      end
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic sc(input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, 8'h00, 32'h0000_0000);
      ck(rd_q & m, e);
   endtask
   // =====
   // Scenarios
   task automatic s_reset();
      sc(32'hFFFF_EFFF, 32'h0000_0080);
      apb(1'b0, 8'h04, 32'h0000_0000);
      ck(rd_q, 32'h0000_0000);
      apb(1'b0, 8'h40, 32'h0000_0000);
      ck({31'h0, err_q}, 32'h0000_0001);
      ck(rd_q, 32'h0000_0000);
      apb(1'b1, 8'h00, 32'hFFFF_FFFF);
      sc(32'h0000_0181, 32'h0000_0080);
   endtask
   task automatic s_latch();
      bat <= 1'b1;
      wt(3);
      ckb(led, 1'b0);
      apb(1'b1, 8'h04, 32'h0000_0010);
      fuse <= 1'b1;
      sdg <= 1'b1;
      dg <= 1'b1;
      wt(2);
      sdg <= 1'b0;
      dg <= 1'b0;
      sc(32'h0000_003D, 32'h0000_003D);
      ckb(led, 1'b1);
      fuse <= 1'b0;
      bat <= 1'b0;
      wt(3);
      ckb(led, 1'b0);
      sc(32'h0000_003D, 32'h0000_0039);
      apb(1'b1, 8'h04, 32'h0000_0014);
      sc(32'h0000_0039, 32'h0000_0000);
      apb(1'b1, 8'h04, 32'h0000_0000);
   endtask
   // Long loss is no short dropout; short one sticks through an error clear
   task automatic s_drop();
      sup <= 1'b1;
      wt(50);
      sup <= 1'b0;
      wt(3);
      sc(32'h0000_0002, 32'h0000_0000);
      dc <= 1'b1;
      sup <= 1'b1;
      wt(10);
      sup <= 1'b0;
      wt(3);
      sc(32'h0000_0002, 32'h0000_0002);
      apb(1'b1, 8'h04, 32'h0000_0004);
      apb(1'b1, 8'h04, 32'h0000_0000);
      sc(32'h0000_0002, 32'h0000_0002);
   endtask
   task automatic s_wdt();
      cause <= 16'h00A5;
      wdt <= 1'b1;
      @(posedge clk_i);
      ckb(stop, 1'b1);
      wdt <= 1'b0;
      cause <= 16'h0000;
      wt(2);
      ckb(stop, 1'b1);
      apb(1'b0, 8'h18, 32'h0000_0000);
      ck(rd_q, 32'h0000_00A5);
      sc(32'h0000_0200, 32'h0000_0200);
      apb(1'b1, 8'h20, 32'h0000_0200);
      ckb(irq, 1'b1);
      apb(1'b1, 8'h20, 32'h0000_0000);
      ckb(irq, 1'b0);
      apb(1'b1, 8'h20, 32'h0000_0200);
      apb(1'b1, 8'h1C, 32'h0000_0200);
      ckb(irq, 1'b0);
      apb(1'b1, 8'h04, 32'h0000_0004);
      apb(1'b1, 8'h04, 32'h0000_0000);
      ckb(stop, 1'b0);
      sc(32'h0000_0200, 32'h0000_0000);
   endtask
   task automatic s_ready();
      pok <= 1'b1;
      apb(1'b1, 8'h04, 32'h0000_0008);
      wt(3);
      sc(32'h0000_0400, 32'h0000_0400);
      apb(1'b1, 8'h04, 32'h0000_0000);
      sc(32'h0000_0400, 32'h0000_0000);
      pok <= 1'b0;
      apb(1'b1, 8'h04, 32'h0000_0008);
      wt(3);
      sc(32'h0000_0400, 32'h0000_0000);
      apb(1'b1, 8'h04, 32'h0000_0000);
   endtask
   task automatic s_test();
      tgr <= 1'b1;
      treq <= 1'b1;
      @(posedge clk_i);
      treq <= 1'b0;
      wt(2);
      sc(32'h0000_2800, 32'h0000_0800);
      tend <= 1'b1;
      @(posedge clk_i);
      tend <= 1'b0;
      wt(2);
      sc(32'h0000_0800, 32'h0000_0000);
      tgr <= 1'b0;
      treq <= 1'b1;
      @(posedge clk_i);
      treq <= 1'b0;
      wt(2);
      sc(32'h0000_2800, 32'h0000_2000);
   endtask
   task automatic s_estop();
      est <= 1'b1;
      wt(40);
      sc(32'h0000_1000, 32'h0000_0000);
      est <= 1'b0;
      wt(40);
      sc(32'h0000_1000, 32'h0000_1000);
   endtask
   // Bad month first, then a valid load, then read back
   task automatic s_clock();
      apb(1'b1, 8'h08, 32'h0000_2413);
      apb(1'b1, 8'h0C, 32'h0000_1712);
      apb(1'b1, 8'h10, 32'h0000_3000);
      apb(1'b1, 8'h14, 32'h0000_0003);
      apb(1'b1, 8'h04, 32'h0000_0001);
      sc(32'h0000_0040, 32'h0000_0040);
      apb(1'b1, 8'h04, 32'h0000_0000);
      apb(1'b1, 8'h08, 32'h0000_2405);
      apb(1'b1, 8'h04, 32'h0000_0001);
      sc(32'h0000_0040, 32'h0000_0000);
      apb(1'b1, 8'h04, 32'h0000_0003);
      wt(3);
      apb(1'b0, 8'h08, 32'h0000_0000);
      ck(rd_q, 32'h0000_2405);
      apb(1'b0, 8'h10, 32'h0000_0000);
      ck({8'h00, rd_q[31:8]}, 32'h0000_0030);
      apb(1'b0, 8'h14, 32'h0000_0000);
      ck(rd_q, 32'h0000_0003);
      apb(1'b1, 8'h04, 32'h0000_0000);
   endtask
   // =====
   // Main sequence
   initial begin
      wt(10);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      s_reset();
      s_latch();
      s_drop();
      s_wdt();
      s_ready();
      s_test();
      s_estop();
      s_clock();
      complete_run();
   end
endmodule // tb
`default_nettype wire
